// ---- hdl/tdc_pkg.sv ----
/*
 * constants, state type and size decoders shared by the two-channel dma engine
 * assumes one 25 MHz clock domain for the engine and its buffer
 */
package tdc_pkg;
    localparam int NCH = 2;
    localparam int AW = 32;
    localparam int DW = 32;
    localparam int UW = 16;
    localparam int FIFO_DEPTH = 8;
    localparam real CLK_MHZ = 25.0;
    localparam logic [1:0] SIZ_8 = 2'h0;
    localparam logic [1:0] SIZ_16 = 2'h1;
    localparam logic [1:0] SIZ_32 = 2'h2;
    localparam logic [1:0] BW_25 = 2'h0;
    localparam logic [1:0] BW_50 = 2'h1;
    localparam logic [1:0] BW_75 = 2'h2;
    localparam logic [1:0] BW_100 = 2'h3;
    localparam logic [31:0] ADDR_RST = 32'h0000_0000;
    localparam logic [31:0] CNT_RST = 32'h0000_0000;
    localparam logic [31:0] DATA_RST = 32'h0000_0000;
    localparam logic [7:0] PACK_RST = 8'h00;
    localparam logic [1:0] SLOT_RST = 2'h0;

    // gray codes along idle, read, write, end
    typedef enum logic [1:0] {
        S_IDLE = 2'h0,
        S_RD = 2'h1,
        S_WR = 2'h3,
        S_END = 2'h2
    } tdc_state_t;

    function automatic logic [2:0] tdc_bytes(input logic [1:0] siz);
        case (siz)
            SIZ_8: tdc_bytes = 3'h1;
            SIZ_16: tdc_bytes = 3'h2;
            default: tdc_bytes = 3'h4;
        endcase
    endfunction : tdc_bytes

    // dual-address ports are 8 or 16 bits wide only
    function automatic logic [1:0] tdc_clamp(input logic [1:0] siz);
        tdc_clamp = (siz == SIZ_8) ? SIZ_8 : SIZ_16;
    endfunction : tdc_clamp
endpackage : tdc_pkg

// ---- hdl/tdc_fifo.sv ----
/*
 * synchronous valid/ready fifo for the packed dual-address data path
 * assumes DEPTH is a power of two and one clock for both sides
 */
`timescale 1ns/1ps
module tdc_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 8
) (
    input logic mclk,
    input logic rstn,
    input logic in_valid,
    output logic in_ready,
    input logic [W-1:0] in_data,
    output logic out_valid,
    input logic out_ready,
    output logic [W-1:0] out_data
);
    localparam int PW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [PW:0] wp_q;
    logic [PW:0] rp_q;
    logic push;
    logic pop;

    // full when the pointers differ only in the wrap bit
    assign in_ready = (wp_q[PW] == rp_q[PW]) || (wp_q[PW-1:0] != rp_q[PW-1:0]);
    assign out_valid = wp_q != rp_q;
    assign out_data = mem[rp_q[PW-1:0]];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wp_q[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wp_q <= '0;
            rp_q <= '0;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
        end
    end
endmodule : tdc_fifo

// ---- hdl/tdc_core.sv ----
/*
 * two-channel dma engine: per-channel programming, request handling,
 * single- and dual-address bus cycles, packing through a fifo
 * assumes a same-clock bus interface with grant and acknowledge, and
 * request pins from outside the clock domain
 */
// Contract
// - the two channels are programmed and run independently
// - each channel has its own request, acknowledge and done line
// - each channel selects single-address or dual-address operation
// - single-address drives one address; the peripheral moves the data
// - single-address transfers start only from an external request
// - single-address uses 32-bit addresses and 8, 16 or 32-bit data
// - dual-address reads the source then writes the destination
// - dual-address starts from internal or external request
// - dual-address uses 32-bit addresses with 8 or 16-bit data
// - independent port sizes; data packed or unpacked when they differ
// - address registers and counters are 32 bits
// - addresses increment or stay constant as programmed
// - external requests run in burst or cycle-steal mode
// - internal requests limited to 25, 50, 75 or 100 percent of bus
// - programmable interrupt on completion that holds the channel busy
// - bus requested during other cycles; dma cycle follows grant directly
// - every dma bus cycle is marked as dma-initiated
`timescale 1ns/1ps
module tdc_core import tdc_pkg::*; #(
    parameter int DEPTH = FIFO_DEPTH
) (
    input logic mclk,
    input logic rstn,
    input logic [NCH-1:0] ch_start,
    input logic [NCH-1:0] ch_dual,
    input logic [NCH-1:0] ch_ext,
    input logic [NCH-1:0] ch_burst,
    input logic [NCH-1:0] ch_sa_dst,
    input logic [NCH-1:0] ch_src_inc,
    input logic [NCH-1:0] ch_dst_inc,
    input logic [NCH-1:0] ch_int_en,
    input logic [NCH-1:0] ch_irq_clr,
    input logic [NCH-1:0][1:0] ch_src_siz,
    input logic [NCH-1:0][1:0] ch_dst_siz,
    input logic [NCH-1:0][AW-1:0] ch_src_addr,
    input logic [NCH-1:0][AW-1:0] ch_dst_addr,
    input logic [NCH-1:0][31:0] ch_count,
    input logic [1:0] bw_sel,
    output logic [NCH-1:0] ch_busy,
    output logic [NCH-1:0] ch_irq,
    input logic [NCH-1:0] dreq_n,
    output logic [NCH-1:0] dack_n,
    output logic [NCH-1:0] done_n,
    output logic bus_req,
    input logic bus_gnt,
    output logic bus_cyc,
    output logic bus_we,
    output logic [1:0] bus_siz,
    output logic [AW-1:0] bus_addr,
    output logic [DW-1:0] bus_wdata,
    input logic [DW-1:0] bus_rdata,
    input logic bus_ack,
    output logic bus_dma_mark
);
    tdc_state_t st_q;
    logic cur_q;
    logic cyc_q;
    logic bus_we_q;
    logic [1:0] bus_siz_q;
    logic [AW-1:0] bus_addr_q;
    logic [DW-1:0] bus_wdata_q;
    logic rsub_q;
    logic wsub_q;
    logic [7:0] pack_q;
    logic [1:0] slot_q;
    logic [AW-1:0] src_q [NCH];
    logic [AW-1:0] dst_q [NCH];
    logic [31:0] rem_q [NCH];
    logic [31:0] rdr_q [NCH];
    logic act_q [NCH];
    logic irq_q [NCH];
    logic rq_m [NCH];
    logic rq_s [NCH];
    logic rq_p [NCH];
    logic steal_q [NCH];
    wire [2:0] sb [NCH];
    wire [2:0] db [NCH];
    wire [2:0] xb [NCH];
    wire [NCH-1:0] ack;
    wire [NCH-1:0] last;
    wire [NCH-1:0] fin;
    wire [NCH-1:0] want;
    logic u2, sb1, db1, unit_rd, need_rd, need, slot_ok, use_dst, go;
    logic f_iv, f_ir, f_ov, f_or;
    logic [UW-1:0] f_in;
    logic [UW-1:0] f_out;
    logic [UW-1:0] wdat;
    logic [1:0] siz_c;

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            assign sb[g] = tdc_bytes(ch_dual[g] ? tdc_clamp(ch_src_siz[g]) : ch_src_siz[g]);
            assign db[g] = tdc_bytes(tdc_clamp(ch_dst_siz[g]));
            assign xb[g] = (st_q == S_WR) ? db[g] : sb[g];
            assign ack[g] = cyc_q && bus_ack && (cur_q == 1'(g));
            assign last[g] = ((st_q == S_WR) || !ch_dual[g]) && (rem_q[g] == {29'h0, xb[g]});
            assign fin[g] = ack[g] && last[g];
            // single-address never runs on an internal request
            assign want[g] = act_q[g] && (rdr_q[g] != 32'h0) &&
                (ch_ext[g] ? (ch_burst[g] ? rq_s[g] : steal_q[g]) : ch_dual[g]);
            assign dack_n[g] = !(cyc_q && cur_q == 1'(g));
            assign done_n[g] = !(cyc_q && cur_q == 1'(g) && last[g]);
            assign ch_busy[g] = act_q[g];
            assign ch_irq[g] = irq_q[g];

            // each channel keeps its own copy; the other channel never writes it
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    src_q[g] <= ADDR_RST;
                    dst_q[g] <= ADDR_RST;
                    rem_q[g] <= CNT_RST;
                    rdr_q[g] <= CNT_RST;
                end else if (ch_start[g] && !act_q[g]) begin
                    src_q[g] <= ch_src_addr[g];
                    dst_q[g] <= ch_dst_addr[g];
                    rem_q[g] <= ch_count[g];
                    rdr_q[g] <= ch_count[g];
                end else if (ack[g]) begin
                    if ((st_q == S_WR) || (!ch_dual[g] && ch_sa_dst[g])) begin
                        if (ch_dst_inc[g]) begin
                            dst_q[g] <= dst_q[g] + {29'h0, xb[g]};
                        end
                    end else if (ch_src_inc[g]) begin
                        src_q[g] <= src_q[g] + {29'h0, xb[g]};
                    end
                    if (st_q == S_RD) begin
                        rdr_q[g] <= rdr_q[g] - {29'h0, xb[g]};
                    end
                    if ((st_q == S_WR) || !ch_dual[g]) begin
                        rem_q[g] <= rem_q[g] - {29'h0, xb[g]};
                    end
                end
            end

            // completion waits for software while the interrupt is pending
            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    act_q[g] <= 1'b0;
                    irq_q[g] <= 1'b0;
                end else begin
                    if (ch_start[g] && !act_q[g] && ch_count[g] != 32'h0) begin
                        act_q[g] <= 1'b1;
                    end else if ((fin[g] && !ch_int_en[g]) || (irq_q[g] && ch_irq_clr[g])) begin
                        act_q[g] <= 1'b0;
                    end
                    if (fin[g] && ch_int_en[g]) begin
                        irq_q[g] <= 1'b1;
                    end else if (ch_irq_clr[g]) begin
                        irq_q[g] <= 1'b0;
                    end
                end
            end

            always_ff @(posedge mclk or negedge rstn) begin
                if (!rstn) begin
                    rq_m[g] <= 1'b0;
                    rq_s[g] <= 1'b0;
                    rq_p[g] <= 1'b0;
                    steal_q[g] <= 1'b0;
                end else begin
                    rq_m[g] <= !dreq_n[g];
                    rq_s[g] <= rq_m[g];
                    rq_p[g] <= rq_s[g];
                    // a new request edge wins over the end-of-unit clear
                    if (rq_s[g] && !rq_p[g]) begin
                        steal_q[g] <= 1'b1;
                    end else if (st_q == S_END && cur_q == 1'(g)) begin
                        steal_q[g] <= 1'b0;
                    end
                end
            end
        end
    endgenerate

    assign u2 = (sb[cur_q] == 3'h2) || (db[cur_q] == 3'h2);
    assign sb1 = sb[cur_q] == 3'h1;
    assign db1 = db[cur_q] == 3'h1;
    assign unit_rd = !(u2 && sb1) || rsub_q;
    // a burst that drops its request still finishes the unit in flight
    assign need_rd = (rdr_q[cur_q] != 32'h0) && f_ir &&
        (rsub_q || !ch_ext[cur_q] || !ch_burst[cur_q] || rq_s[cur_q]);
    assign need = (st_q == S_RD) ? (ch_dual[cur_q] ? need_rd : 1'b1) : ((st_q == S_WR) && f_ov);
    assign slot_ok = ch_ext[cur_q] || (slot_q <= bw_sel);
    assign bus_req = need && !cyc_q && slot_ok;
    assign go = bus_req && bus_gnt;
    assign use_dst = (st_q == S_WR) || (!ch_dual[cur_q] && ch_sa_dst[cur_q]);
    assign siz_c = (st_q == S_WR) ? tdc_clamp(ch_dst_siz[cur_q]) :
        (ch_dual[cur_q] ? tdc_clamp(ch_src_siz[cur_q]) : ch_src_siz[cur_q]);
    // big-endian packing: first byte read lands in the upper half
    assign f_in = sb1 ? {pack_q, bus_rdata[7:0]} : bus_rdata[15:0];
    assign f_iv = (st_q == S_RD) && ch_dual[cur_q] && ack[cur_q] && unit_rd;
    assign f_or = (st_q == S_WR) && cyc_q && bus_ack && (!(u2 && db1) || wsub_q);
    assign wdat = !db1 ? f_out : {8'h00, (u2 && !wsub_q) ? f_out[15:8] : f_out[7:0]};
    assign bus_cyc = cyc_q;
    assign bus_we = bus_we_q;
    assign bus_siz = bus_siz_q;
    assign bus_addr = bus_addr_q;
    assign bus_wdata = bus_wdata_q;
    assign bus_dma_mark = cyc_q;

    tdc_fifo #(
        .W(UW),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rstn(rstn),
        .in_valid(f_iv),
        .in_ready(f_ir),
        .in_data(f_in),
        .out_valid(f_ov),
        .out_ready(f_or),
        .out_data(f_out)
    );

    // four-slot window: the share code is the last slot an internal channel may use
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            slot_q <= SLOT_RST;
        end else begin
            slot_q <= slot_q + 2'h1;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            st_q <= S_IDLE;
            cur_q <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (|want) begin
                        st_q <= S_RD;
                        cur_q <= want[!cur_q] ? !cur_q : cur_q;
                    end
                end
                S_RD: begin
                    if (!ch_dual[cur_q]) begin
                        if (ack[cur_q]) begin
                            st_q <= S_END;
                        end
                    end else if (cyc_q) begin
                        if (f_iv && ch_ext[cur_q] && !ch_burst[cur_q]) begin
                            st_q <= S_WR;
                        end
                    end else if (!need_rd) begin
                        st_q <= f_ov ? S_WR : S_END;
                    end
                end
                S_WR: begin
                    if (!cyc_q && !f_ov) begin
                        st_q <= S_END;
                    end
                end
                S_END: st_q <= S_IDLE;
                default: st_q <= S_IDLE;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rsub_q <= 1'b0;
            wsub_q <= 1'b0;
            pack_q <= PACK_RST;
        end else if (st_q == S_IDLE) begin
            rsub_q <= 1'b0;
            wsub_q <= 1'b0;
        end else if (cyc_q && bus_ack) begin
            if (st_q == S_RD) begin
                pack_q <= bus_rdata[7:0];
                if (u2 && sb1) begin
                    rsub_q <= !rsub_q;
                end
            end
            if (st_q == S_WR && u2 && db1) begin
                wsub_q <= !wsub_q;
            end
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            cyc_q <= 1'b0;
            bus_we_q <= 1'b0;
            bus_siz_q <= SIZ_8;
            bus_addr_q <= ADDR_RST;
            bus_wdata_q <= DATA_RST;
        end else if (go) begin
            cyc_q <= 1'b1;
            bus_we_q <= use_dst;
            bus_siz_q <= siz_c;
            bus_addr_q <= use_dst ? dst_q[cur_q] : src_q[cur_q];
            bus_wdata_q <= {16'h0000, wdat};
        end else if (bus_ack) begin
            cyc_q <= 1'b0;
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    property p_indep;
        st_q != S_IDLE && !cur_q && !ch_start[1] |=> $stable(rem_q[1]) && $stable(src_q[1]);
    endproperty
    a_indep: assert property (p_indep) else $error("idle channel state moved");
    property p_dack;
        cyc_q |-> !dack_n[cur_q] && dack_n[!cur_q];
    endproperty
    a_dack: assert property (p_dack) else $error("acknowledge on wrong channel");
    property p_flyaddr;
        $rose(cyc_q) && !ch_dual[cur_q] |-> bus_addr_q == (ch_sa_dst[cur_q] ? dst_q[cur_q] : src_q[cur_q]);
    endproperty
    a_flyaddr: assert property (p_flyaddr) else $error("flyby address wrong");
    property p_flyext;
        $rose(cyc_q) && !ch_dual[cur_q] |-> ch_ext[cur_q];
    endproperty
    a_flyext: assert property (p_flyext) else $error("flyby without external request");
    property p_dualsiz;
        cyc_q && ch_dual[cur_q] |-> bus_siz_q != SIZ_32;
    endproperty
    a_dualsiz: assert property (p_dualsiz) else $error("dual cycle sized 32");
    property p_pack;
        cyc_q && bus_ack && st_q == S_RD && u2 && sb1 && !rsub_q |=> rsub_q && !f_iv;
    endproperty
    a_pack: assert property (p_pack) else $error("pack byte lost");
    property p_hold;
        cyc_q && bus_ack && st_q == S_RD && ch_dual[cur_q] && !ch_src_inc[cur_q] |=> $stable(src_q[cur_q]);
    endproperty
    a_hold: assert property (p_hold) else $error("fixed source moved");
    property p_bw;
        $rose(cyc_q) && !ch_ext[cur_q] |-> $past(slot_q) <= $past(bw_sel);
    endproperty
    a_bw: assert property (p_bw) else $error("bandwidth share exceeded");
    property p_b2b;
        bus_req && bus_gnt |=> cyc_q && bus_dma_mark;
    endproperty
    a_b2b: assert property (p_b2b) else $error("granted cycle not started");
    property p_done;
        !done_n[0] && bus_ack |=> rem_q[0] == 32'h0 && (!act_q[0] || irq_q[0]);
    endproperty
    a_done: assert property (p_done) else $error("done without block end");
    property p_irq;
        !done_n[1] && bus_ack && ch_int_en[1] |=> irq_q[1] && act_q[1];
    endproperty
    a_irq: assert property (p_irq) else $error("completion interrupt missing");

    c_fly: cover property (!done_n[0] && !ch_dual[0] && bus_ack);
    c_unpack: cover property (st_q == S_WR && u2 && db1 && wsub_q && bus_ack);
    c_full: cover property (st_q == S_RD && !f_ir);
endmodule : tdc_core

// ---- dv/tdc_mem_model.sv ----
/*
 * dma far side: grant, memory data, ack delay, log of dma cycles
 * assumes the engine's bus ports on the same mclk
 */
`timescale 1ns/1ps
module tdc_mem_model import tdc_pkg::*; (
    input logic mclk,
    input logic rstn,
    input logic bus_req,
    output logic bus_gnt,
    input logic bus_cyc,
    input logic bus_we,
    input logic [1:0] bus_siz,
    input logic [AW-1:0] bus_addr,
    input logic [DW-1:0] bus_wdata,
    output logic [DW-1:0] bus_rdata,
    output logic bus_ack,
    input logic bus_dma_mark,
    input logic [NCH-1:0] dack_n,
    input logic [NCH-1:0] done_n
);
    int ack_wait = 0, gnt_gap = 0, wait_cnt, now;
    logic [31:0] junk_q;
    logic [71:0] lg[$];
    int lg_t[$];

    function automatic logic [7:0] mem_byte(input logic [31:0] a);
        return a[7:0] ^ {a[11:8], a[15:12]} ^ 8'h5A;
    endfunction : mem_byte

    // ack_wait 0 answers in the first cycle of bus_cyc
    assign bus_ack = bus_cyc && (wait_cnt >= ack_wait);

    // undriven bytes show a pattern that changes every cycle, never the last value
    always_comb begin
        bus_rdata = junk_q;
        if (bus_cyc && !bus_we) begin
            case (bus_siz)
                SIZ_8: bus_rdata[7:0] = mem_byte(bus_addr);
                SIZ_16: bus_rdata[15:0] = {mem_byte(bus_addr), mem_byte(bus_addr + 32'h1)};
                default: bus_rdata = {mem_byte(bus_addr), mem_byte(bus_addr + 32'h1),
                    mem_byte(bus_addr + 32'h2), mem_byte(bus_addr + 32'h3)};
            endcase
        end
    end

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            wait_cnt <= 0;
            now <= 0;
            junk_q <= 32'hC3A5_0F96;
            bus_gnt <= 1'b1;
        end else begin
            now <= now + 1;
            junk_q <= junk_q + 32'h9E37_79B9;
            // processor cycles take the bus now and then; grant drops meanwhile
            bus_gnt <= ($urandom_range(gnt_gap, 0) == 0);
            wait_cnt <= (bus_cyc && !bus_ack) ? wait_cnt + 1 : 0;
            if (bus_req && bus_gnt && !bus_cyc) lg_t.push_back(now);
            if (bus_ack) lg.push_back({bus_dma_mark, done_n, dack_n, bus_we, bus_siz, bus_addr, bus_wdata});
        end
    end
endmodule : tdc_mem_model

// ---- dv/two_channel_dma_controller_bench.sv ----
/*
 * dma engine bench: dual-address, flyby, cycle steal, irq hold, independence
 * assumes tdc_mem_model as far side, 25 MHz mclk
 */
`timescale 1ns/1ps
module two_channel_dma_controller_bench import tdc_pkg::*;;
    logic mclk = 1'b0;
    logic rstn;
    logic [NCH-1:0] ch_start, ch_dual, ch_ext, ch_burst, ch_sa_dst, ch_src_inc, ch_dst_inc, ch_int_en, ch_irq_clr;
    logic [NCH-1:0][1:0] ch_src_siz, ch_dst_siz;
    logic [NCH-1:0][AW-1:0] ch_src_addr, ch_dst_addr;
    logic [NCH-1:0][31:0] ch_count;
    logic [1:0] bw_sel;
    logic [NCH-1:0] ch_busy, ch_irq, dreq_n, dack_n, done_n;
    logic bus_req, bus_gnt, bus_cyc, bus_we, bus_ack, bus_dma_mark;
    logic [1:0] bus_siz;
    logic [AW-1:0] bus_addr;
    logic [DW-1:0] bus_wdata, bus_rdata;
    int fail_count = 0;
    int total_checks = 0;
    logic [71:0] exp_q[$], msk_q[$];

    always #20 mclk = ~mclk;

    tdc_core dut (.mclk, .rstn, .ch_start, .ch_dual, .ch_ext, .ch_burst, .ch_sa_dst, .ch_src_inc, .ch_dst_inc,
        .ch_int_en, .ch_irq_clr, .ch_src_siz, .ch_dst_siz, .ch_src_addr, .ch_dst_addr, .ch_count, .bw_sel,
        .ch_busy, .ch_irq, .dreq_n, .dack_n, .done_n, .bus_req, .bus_gnt, .bus_cyc, .bus_we, .bus_siz,
        .bus_addr, .bus_wdata, .bus_rdata, .bus_ack, .bus_dma_mark);

    tdc_mem_model mdl (.mclk, .rstn, .bus_req, .bus_gnt, .bus_cyc, .bus_we, .bus_siz, .bus_addr, .bus_wdata,
        .bus_rdata, .bus_ack, .bus_dma_mark, .dack_n, .done_n);

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [71:0] exp, input logic [71:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic do_reset();
        rstn = 1'b0;
        repeat (4) @(negedge mclk);
        rstn = 1'b1;
        @(negedge mclk);
        check("reset state", 72'h1E, {63'h0, ch_busy, ch_irq, dack_n, done_n, bus_cyc | bus_req});
    endtask : do_reset

    // log entry: mark, done_n, dack_n, we, siz, addr, wdata
    task automatic exp_push(input int ch, input logic we, input logic [1:0] siz, input logic [31:0] a,
        input logic [31:0] wd, input logic [31:0] wm, input logic last);
        logic [1:0] sel;
        sel = 2'h3;
        sel[ch] = 1'b0;
        exp_q.push_back({1'b1, last ? sel : 2'h3, sel, we, siz, a, wd & wm});
        msk_q.push_back({40'hFF_FFFF_FFFF, wm});
    endtask : exp_push

    task automatic plan_dual(input int ch, input logic [1:0] ssz, input logic [1:0] dsz, input logic [31:0] src,
        input logic [31:0] dst, input int cnt, input logic inc);
        logic [7:0] b[$];
        int sb, db;
        logic [31:0] a;
        sb = (ssz == SIZ_8) ? 1 : 2;
        db = (dsz == SIZ_8) ? 1 : 2;
        for (int i = 0; i < cnt / sb; i++) begin
            a = inc ? src + 32'(i * sb) : src;
            exp_push(ch, 1'b0, ssz, a, 32'h0, 32'h0, 1'b0);
            b.push_back(mdl.mem_byte(a));
            if (sb == 2) b.push_back(mdl.mem_byte(a + 32'h1));
        end
        // first byte read is the upper half
        for (int j = 0; j < cnt / db; j++) begin
            a = inc ? dst + 32'(j * db) : dst;
            if (db == 2) exp_push(ch, 1'b1, dsz, a, {16'h0, b[2 * j], b[2 * j + 1]}, 32'hFFFF, j == cnt / 2 - 1);
            else exp_push(ch, 1'b1, dsz, a, {24'h0, b[j]}, 32'hFF, j == cnt - 1);
        end
    endtask : plan_dual

    task automatic launch(input int ch, input logic dual, input logic ext, input logic burst, input logic sadst,
        input logic inc, input logic [1:0] ssz, input logic [1:0] dsz, input logic [31:0] src,
        input logic [31:0] dst, input logic [31:0] cnt, input logic ie);
        ch_dual[ch] = dual;
        ch_ext[ch] = ext;
        ch_burst[ch] = burst;
        ch_sa_dst[ch] = sadst;
        ch_src_inc[ch] = inc;
        ch_dst_inc[ch] = inc;
        ch_int_en[ch] = ie;
        ch_src_siz[ch] = ssz;
        ch_dst_siz[ch] = dsz;
        ch_src_addr[ch] = src;
        ch_dst_addr[ch] = dst;
        ch_count[ch] = cnt;
        ch_start[ch] = 1'b1;
        @(negedge mclk);
        ch_start[ch] = 1'b0;
    endtask : launch

    // bounded wait; a hang shows up as a busy channel
    task automatic wait_idle(input int ch);
        int t;
        t = 0;
        while (ch_busy[ch] !== 1'b0 && t < 2000) begin
            @(negedge mclk);
            t++;
        end
        check("busy end", 72'h0, {71'h0, ch_busy[ch]});
    endtask : wait_idle

    task automatic compare_log(input string what, input logic slots);
        check({what, " cycles"}, 72'(exp_q.size()), 72'(mdl.lg.size()));
        check({what, " starts"}, 72'(mdl.lg.size()), 72'(mdl.lg_t.size()));
        for (int i = 0; i < exp_q.size() && i < mdl.lg.size(); i++) begin
            check(what, exp_q[i], mdl.lg[i] & msk_q[i]);
            if (slots && i > 0) check("share gap", 72'h1, 72'(mdl.lg_t[i] - mdl.lg_t[i - 1] >= 4));
        end
        exp_q.delete();
        msk_q.delete();
        mdl.lg.delete();
        mdl.lg_t.delete();
    endtask : compare_log

    initial begin
        #(40 * 30000);
        fail_count++;
        $display("watchdog expired");
        print_verdict();
    end

    initial begin
        int ch, cnt, k;
        logic [1:0] ssz, dsz;
        logic [31:0] src, dst;
        {ch_start, ch_dual, ch_ext, ch_burst, ch_sa_dst, ch_src_inc, ch_dst_inc, ch_int_en, ch_irq_clr} = '0;
        {ch_src_siz, ch_dst_siz, ch_src_addr, ch_dst_addr, ch_count, bw_sel} = '0;
        dreq_n = 2'h3;
        k = $urandom(32'h9E80);
        do_reset();
        // dual: pack, unpack, held address, random
        for (int n = 0; n < 14; n++) begin
            ch = (n < 3) ? n % 2 : $urandom_range(1, 0);
            ssz = (n == 0) ? SIZ_8 : (n == 1) ? SIZ_16 : 2'($urandom_range(1, 0));
            dsz = (n == 0) ? SIZ_16 : (n == 1) ? SIZ_8 : 2'($urandom_range(1, 0));
            cnt = 2 * $urandom_range(4, 1);
            src = $urandom & 32'hFFFF_FFFE;
            dst = $urandom & 32'hFFFF_FFFE;
            bw_sel = 2'(n % 4);
            mdl.ack_wait = $urandom_range(2, 0);
            mdl.gnt_gap = $urandom_range(2, 0);
            plan_dual(ch, ssz, dsz, src, dst, cnt, n != 2);
            launch(ch, 1'b1, 1'b0, 1'b1, 1'b0, n != 2, ssz, dsz, src, dst, 32'(cnt), 1'b0);
            wait_idle(ch);
            compare_log("dual", bw_sel == BW_25);
        end
        // flyby burst: 32-bit writes advancing, byte reads held
        for (int m = 0; m < 2; m++) begin
            ch = 1 - m;
            ssz = m ? SIZ_8 : SIZ_32;
            cnt = m ? 3 : 12;
            src = $urandom & 32'hFFFF_FFFC;
            dst = $urandom & 32'hFFFF_FFFC;
            for (int i = 0; i < 3; i++) begin
                exp_push(ch, !m, ssz, m ? src : dst + 32'(4 * i), 32'h0, 32'h0, i == 2);
            end
            launch(ch, 1'b0, 1'b1, 1'b1, !m, !m, ssz, ssz, src, dst, 32'(cnt), 1'b0);
            dreq_n[ch] = 1'b0;
            wait_idle(ch);
            dreq_n[ch] = 1'b1;
            compare_log("flyby", 1'b0);
        end
        // cycle steal: one unit per request edge; grant held so each unit fits the wait
        mdl.gnt_gap = 0;
        src = $urandom & 32'hFFFF_FFFE;
        exp_push(0, 1'b0, SIZ_16, src, 32'h0, 32'h0, 1'b0);
        exp_push(0, 1'b0, SIZ_16, src + 32'h2, 32'h0, 32'h0, 1'b1);
        launch(0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b1, SIZ_16, SIZ_16, src, 32'h0, 32'h4, 1'b0);
        for (int p = 0; p < 2; p++) begin
            dreq_n[0] = 1'b0;
            repeat (3) @(negedge mclk);
            dreq_n[0] = 1'b1;
            repeat (20) @(negedge mclk);
            check("steal units", 72'(p + 1), 72'(mdl.lg.size()));
        end
        wait_idle(0);
        compare_log("steal", 1'b0);
        // irq holds busy until cleared
        src = $urandom & 32'hFFFF_FFFE;
        plan_dual(1, SIZ_8, SIZ_8, src, src + 32'h100, 2, 1'b1);
        launch(1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, SIZ_8, SIZ_8, src, src + 32'h100, 32'h2, 1'b1);
        for (k = 0; k < 500 && ch_irq[1] !== 1'b1; k++) @(negedge mclk);
        repeat (5) @(negedge mclk);
        check("irq hold", 72'h3, {70'h0, ch_irq[1], ch_busy[1]});
        ch_irq_clr[1] = 1'b1;
        @(negedge mclk);
        ch_irq_clr[1] = 1'b0;
        @(negedge mclk);
        check("irq clear", 72'h0, {70'h0, ch_irq[1], ch_busy[1]});
        compare_log("irq", 1'b0);
        // internal flyby never runs nor disturbs the other channel
        launch(0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1, SIZ_8, SIZ_8, src, src, 32'h4, 1'b0);
        plan_dual(1, SIZ_16, SIZ_16, src, src + 32'h40, 4, 1'b1);
        launch(1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1, SIZ_16, SIZ_16, src, src + 32'h40, 32'h4, 1'b0);
        wait_idle(1);
        repeat (30) @(negedge mclk);
        compare_log("independent", 1'b0);
        check("flyby internal busy", 72'h1, {71'h0, ch_busy[0]});
        do_reset();
        print_verdict();
    end
endmodule : two_channel_dma_controller_bench
